// ### rtl/pia_pkg.sv
package pia_pkg;

  localparam int NUM_SRC   = 18;
  localparam int NUM_L1    = 7;
  localparam int NUM_PINS  = 5;
  localparam int NUM_LINES = 6;

  // core ranks
  localparam logic [3:0] RANK_EMU   = 4'h2;
  localparam logic [3:0] RANK_NMI   = 4'h3;
  localparam logic [3:0] RANK_LINE1 = 4'h4;

  // core vectors and offsets
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_EMU     = 16'h0026;
  localparam logic [15:0] VEC_NMI     = 16'h0024;
  localparam logic [15:0] OFS_NMI     = 16'h0002;
  localparam logic [15:0] OFS_PHANTOM = 16'h0000;
  localparam logic [15:0] LINE_VEC [NUM_LINES] =
    '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C};

  // source offsets in chain order, highest priority first
  localparam logic [15:0] SRC_OFS [NUM_SRC] = '{
    16'h0001, 16'h0011, 16'h001F, 16'h0005, 16'h0006, 16'h0007, 16'h0010,
    16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026,
    16'h0027, 16'h0028, 16'h0029, 16'h002A};

  // register word indices of the vector registers; byte address is 4x
  localparam logic [15:0] SYS_VEC_IDX = 16'h701E;
  localparam logic [15:0] EVA_VEC_IDX = 16'h7432;
  localparam logic [17:0] SYS_VEC_ADDR = {SYS_VEC_IDX, 2'b00};
  localparam logic [17:0] EVA_VEC_ADDR = {EVA_VEC_IDX, 2'b00};

  // control registers (byte addresses)
  localparam logic [17:0] ST0_ADDR      = 18'h0_0000;
  localparam logic [17:0] MASK_ADDR     = 18'h0_0004;
  localparam logic [17:0] PEND_ADDR     = 18'h0_0008;
  localparam logic [17:0] ISTAT_ADDR    = 18'h0_0010;
  localparam logic [17:0] ICLR_ADDR     = 18'h0_0014;
  localparam logic [17:0] IEN_ADDR      = 18'h0_0018;
  localparam logic [17:0] SRC_BASE_ADDR = 18'h0_0100;

  localparam int GDIS_BIT   = 9;
  localparam int FLAG_BIT   = 0;
  localparam int ENABLE_BIT = 1;
  localparam int NUM_EVT    = 7;
  localparam int EVT_PHANTOM = 6;

  localparam logic [15:0] ST0_RST  = 16'h0200;
  localparam logic [5:0]  MASK_RST = 6'h00;

  typedef struct packed {
    logic enable;
    logic flag;
  } pia_src_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  rank;
    logic [15:0] vector;
  } pia_core_req_t;

endpackage : pia_pkg

// ### rtl/pia_arbiter.sv
// How it works
// - core lines ranked 1..10, highest acknowledged first
// - nonmaskable rank 3, lines 1-6 ranks 4-9
// - system drives lines 1,5,6, events 2-4
// - each line chains sources in fixed priority
// - each source has flag, enable; request sets flag
// - only enabled flags arbitrate; highest one passes
// - passed request sets line pending bit
// - global disable bit 9 holds off maskables
// - disable set at reset, on any acknowledge, on non-trap soft interrupt
// - line acknowledged only while mask bit is 1
// - acknowledge jams soft interrupt with line vector
// - vector register shows serviced source offset
// - no requesting source reads phantom offset 0000h
// - reset 0000h, emulator 0026h, nonmaskable 0024h/0002h
// - line 1 sources: three pins 0001h,0011h,001Fh
// - then serial 0005h,0006h,0007h, tick 0010h
// - line 2: drive protect 0020h, compares 0021h-0023h
// - simple compares 0024h-0026h, timer 0027h-002Ah
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter
  import pia_pkg::*;
(
  input  wire logic        clk_in,             // 200 MHz system clock
  input  wire logic        reset_in,           // async reset, active high
  input  wire logic        psel_in,            // apb select
  input  wire logic        penable_in,         // apb enable
  input  wire logic        pwrite_in,          // apb direction
  input  wire logic [17:0] paddr_in,           // apb byte address
  input  wire logic [31:0] pwdata_in,          // apb write data
  output logic      [31:0] prdata_out,         // apb read data
  output logic             pready_out,         // apb ready
  output logic             pslverr_out,        // apb error, unmapped
  input  wire logic [2:0]  ext_pin_irq_in,     // pins a,b,c, active high
  input  wire logic        power_drive_protect_irq_in, // pin, active high
  input  wire logic        nmi_pin_low_in,     // nonmaskable pin, active low
  input  wire logic [3:0]  sys_periph_irq_in,  // spi, rx, tx, tick
  input  wire logic [9:0]  ev_group_a_irq_in,  // cmp a-c, scmp a-c, timer p,c,u,o
  input  wire logic [3:0]  line_req_in,        // lines 3-6 from other chains
  input  wire logic        emu_trap_in,        // emulator trap request
  input  wire logic        cpu_ack_in,         // core acknowledges presented req
  input  wire logic        cpu_swint_in,       // software interrupt executed
  input  wire logic        cpu_swint_trap_in,  // with swint: it is a trap
  output logic             core_req_out,       // request to core
  output logic      [3:0]  core_rank_out,      // rank of presented request
  output logic      [15:0] core_vector_out,    // vector of presented request
  output logic             soft_interrupt_instruction_jam_out,       // soft interrupt jam pulse
  output logic      [15:0] jam_vector_out,     // vector of jammed instruction
  output logic             global_irq_disable_out, // disable bit
  output logic             irq_out             // block interrupt, level
);

  // pin synchronisers: pins a,b,c, drive protect, nmi (inverted)
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r, pin_prev_r;
  logic [NUM_PINS-1:0] pin_rise;
  assign pin_raw = {~nmi_pin_low_in, power_drive_protect_irq_in, ext_pin_irq_in};

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      always_ff @(posedge clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          pin_s1_r[gp]     <= 1'b0;
          pin_s2_r[gp]     <= 1'b0;
          pin_s3_r[gp]     <= 1'b0;
          pin_stable_r[gp] <= 1'b0;
          pin_prev_r[gp]   <= 1'b0;
        end
        else
        begin
          pin_s1_r[gp] <= pin_raw[gp];
          pin_s2_r[gp] <= pin_s1_r[gp];
          pin_s3_r[gp] <= pin_s2_r[gp];
          if (pin_s2_r[gp] == pin_s3_r[gp])
            pin_stable_r[gp] <= pin_s3_r[gp];
          pin_prev_r[gp] <= pin_stable_r[gp];
        end
      end
      assign pin_rise[gp] = pin_stable_r[gp] & ~pin_prev_r[gp];
    end
  endgenerate

  // apb decode
  logic apb_wr, apb_setup;
  assign apb_wr    = psel_in & penable_in & pready_out & pwrite_in;
  assign apb_setup = psel_in & ~penable_in;

  // per-source control registers
  logic [NUM_SRC-1:0] src_evt, src_flag_r, src_en_r, src_fwd;
  pia_src_ctrl_t      src_ctrl [NUM_SRC];
  assign src_evt = {ev_group_a_irq_in, pin_rise[3], sys_periph_irq_in,
                    pin_rise[2:0]};

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++)
    begin : g_src
      logic src_wr;
      assign src_wr = apb_wr && (paddr_in == SRC_BASE_ADDR + 18'(gs * 4));
      always_ff @(posedge clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          src_flag_r[gs] <= 1'b0;
          src_en_r[gs]   <= 1'b0;
        end
        else
        begin
          // request sets, write-1 clears, set wins
          src_flag_r[gs] <= src_evt[gs] |
            (src_flag_r[gs] & ~(src_wr & pwdata_in[FLAG_BIT]));
          if (src_wr)
            src_en_r[gs] <= pwdata_in[ENABLE_BIT];
        end
      end
      assign src_fwd[gs] = src_flag_r[gs] & src_en_r[gs];
      assign src_ctrl[gs] = '{enable: src_en_r[gs], flag: src_flag_r[gs]};

      src_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        src_evt[gs] |=> src_flag_r[gs])
        else $error("source request did not set flag");
    end
  endgenerate

  // chain arbitration: lowest index wins within a line
  logic        line1_any, line2_any;
  logic [15:0] line1_ofs, line2_ofs;
  always_comb
  begin
    line1_ofs = OFS_PHANTOM;
    line2_ofs = OFS_PHANTOM;
    for (int i = NUM_L1 - 1; i >= 0; i--)
      if (src_fwd[i])
        line1_ofs = SRC_OFS[i];
    for (int i = NUM_SRC - 1; i >= NUM_L1; i--)
      if (src_fwd[i])
        line2_ofs = SRC_OFS[i];
  end
  assign line1_any = |src_fwd[NUM_L1-1:0];
  assign line2_any = |src_fwd[NUM_SRC-1:NUM_L1];

  // core state
  logic [15:0]          st0_r;
  logic [NUM_LINES-1:0] line_mask_r, line_mask_nxt, line_pend_r, line_pend_nxt, line_set;
  logic                 nmi_pend_r, nmi_pend_nxt, emu_pend_r, emu_pend_nxt;
  logic                 gdis_nxt, ack;
  pia_core_req_t        core_r, core_nxt;
  logic [3:0]           ack_sel_r, sel_nxt; // 0 emu, 1 nmi, n+1 line n (1..6)
  logic                 phantom_evt;

  assign ack      = cpu_ack_in & core_r.valid;
  assign line_set = {line_req_in, line2_any, line1_any};

  always_comb
  begin
    line_pend_nxt = line_pend_r | line_set;
    nmi_pend_nxt  = nmi_pend_r | pin_rise[4];
    emu_pend_nxt  = emu_pend_r | emu_trap_in;
    if (ack)
    begin
      unique case (ack_sel_r)
        4'd0:    emu_pend_nxt = emu_trap_in;
        4'd1:    nmi_pend_nxt = pin_rise[4];
        default: line_pend_nxt[3'(ack_sel_r - 4'd2)] = line_set[3'(ack_sel_r - 4'd2)];
      endcase
    end
  end

  // a mask write gates the line at the same edge as the register
  always_comb
  begin
    line_mask_nxt = line_mask_r;
    if (apb_wr && paddr_in == MASK_ADDR)
      line_mask_nxt = pwdata_in[NUM_LINES-1:0];
  end

  // software write, then hardware set wins
  always_comb
  begin
    gdis_nxt = st0_r[GDIS_BIT];
    if (apb_wr && paddr_in == ST0_ADDR)
      gdis_nxt = pwdata_in[GDIS_BIT];
    if (ack || (cpu_swint_in && !cpu_swint_trap_in))
      gdis_nxt = 1'b1;
  end

  // core priority: emu, nmi, then lines 1..6
  always_comb
  begin
    core_nxt = '{valid: 1'b0, rank: 4'h0, vector: VEC_RESET};
    sel_nxt  = 4'd0;
    for (int n = NUM_LINES - 1; n >= 0; n--)
      if (line_pend_nxt[n] && line_mask_nxt[n] && !gdis_nxt)
      begin
        core_nxt = '{valid: 1'b1, rank: RANK_LINE1 + 4'(n), vector: LINE_VEC[n]};
        sel_nxt  = 4'(n + 2);
      end
    if (nmi_pend_nxt)
    begin
      core_nxt = '{valid: 1'b1, rank: RANK_NMI, vector: VEC_NMI};
      sel_nxt  = 4'd1;
    end
    if (emu_pend_nxt)
    begin
      core_nxt = '{valid: 1'b1, rank: RANK_EMU, vector: VEC_EMU};
      sel_nxt  = 4'd0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st0_r       <= ST0_RST;
      line_mask_r <= MASK_RST;
      line_pend_r <= '0;
      nmi_pend_r  <= 1'b0;
      emu_pend_r  <= 1'b0;
      core_r      <= '{valid: 1'b0, rank: 4'h0, vector: VEC_RESET};
      ack_sel_r   <= 4'd0;
    end
    else
    begin
      st0_r[GDIS_BIT] <= gdis_nxt;
      line_mask_r <= line_mask_nxt;
      line_pend_r <= line_pend_nxt;
      nmi_pend_r  <= nmi_pend_nxt;
      emu_pend_r  <= emu_pend_nxt;
      core_r      <= core_nxt;
      ack_sel_r   <= sel_nxt;
    end
  end

  // jam soft interrupt with the acknowledged vector
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      soft_interrupt_instruction_jam_out   <= 1'b0;
      jam_vector_out <= VEC_RESET;
    end
    else
    begin
      soft_interrupt_instruction_jam_out <= ack;
      if (ack)
        jam_vector_out <= core_r.vector;
    end
  end

  assign core_req_out           = core_r.valid;
  assign core_rank_out          = core_r.rank;
  assign core_vector_out        = core_r.vector;
  assign global_irq_disable_out = st0_r[GDIS_BIT];

  // block interrupt: sticky status, enable, write-1 clear
  logic [NUM_EVT-1:0] istat_r, ien_r, evt;
  assign phantom_evt = ack && ((ack_sel_r == 4'd2 && !line1_any) ||
                               (ack_sel_r == 4'd3 && !line2_any));
  assign evt = {phantom_evt, line_set & ~line_pend_r};

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      istat_r <= '0;
      ien_r   <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr_in == ICLR_ADDR)
        istat_r <= (istat_r & ~pwdata_in[NUM_EVT-1:0]) | evt;
      else
        istat_r <= istat_r | evt;
      if (apb_wr && paddr_in == IEN_ADDR)
        ien_r <= pwdata_in[NUM_EVT-1:0];
      irq_out <= |(istat_r & ien_r);
    end
  end

  // apb slave: no wait states, data captured at setup
  logic [31:0] rdata_nxt;
  logic        hit;
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    hit       = 1'b1;
    if (paddr_in >= SRC_BASE_ADDR && paddr_in < SRC_BASE_ADDR + 18'(NUM_SRC * 4)
        && paddr_in[1:0] == 2'b00)
      rdata_nxt = {30'h0000_0000, src_ctrl[5'((paddr_in - SRC_BASE_ADDR) >> 2)]};
    else
    begin
      unique case (paddr_in)
        ST0_ADDR:     rdata_nxt = {16'h0000, st0_r};
        MASK_ADDR:    rdata_nxt = {26'h000_0000, line_mask_r};
        PEND_ADDR:    rdata_nxt = {26'h000_0000, line_pend_r};
        ISTAT_ADDR:   rdata_nxt = {25'h000_0000, istat_r};
        ICLR_ADDR:    rdata_nxt = 32'h0000_0000;
        IEN_ADDR:     rdata_nxt = {25'h000_0000, ien_r};
        SYS_VEC_ADDR: rdata_nxt = {16'h0000, line1_ofs};
        EVA_VEC_ADDR: rdata_nxt = {16'h0000, line2_ofs};
        default:      hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup & ~hit;
      prdata_out  <= (apb_setup && !pwrite_in) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // checks
  ack_sets_disable_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ack |=> global_irq_disable_out)
    else $error("acknowledge did not set global disable");

  mask_gates_line_a: assert property (@(posedge clk_in) disable iff (reset_in)
    core_req_out && core_rank_out >= RANK_LINE1 |->
      line_mask_r[3'(core_rank_out - RANK_LINE1)])
    else $error("masked line presented to core");

  disable_holds_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
    core_req_out && core_rank_out >= RANK_LINE1 |-> !global_irq_disable_out)
    else $error("maskable line presented while disabled");

  nmi_over_lines_a: assert property (@(posedge clk_in) disable iff (reset_in)
    core_req_out && core_rank_out > RANK_NMI |-> !nmi_pend_r && !emu_pend_r)
    else $error("lower line presented over nonmaskable");

  pending_set_a: assert property (@(posedge clk_in) disable iff (reset_in)
    line1_any && !ack |=> line_pend_r[0])
    else $error("line 1 pending not set");

  jam_vector_a: assert property (@(posedge clk_in) disable iff (reset_in)
    ack |=> soft_interrupt_instruction_jam_out && jam_vector_out == $past(core_vector_out))
    else $error("jam missing or wrong vector");

  phantom_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
    apb_setup && !pwrite_in && paddr_in == SYS_VEC_ADDR && !line1_any
      |=> prdata_out == 32'h0000_0000)
    else $error("phantom offset not returned");

  line1_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
    apb_setup && !pwrite_in && paddr_in == SYS_VEC_ADDR && src_fwd[0]
      |=> prdata_out == 32'h0000_0001)
    else $error("line 1 top source offset wrong");

  line2_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
    apb_setup && !pwrite_in && paddr_in == EVA_VEC_ADDR && src_fwd[7]
      |=> prdata_out == 32'h0000_0020)
    else $error("line 2 top source offset wrong");

  line2_phantom_a: assert property (@(posedge clk_in) disable iff (reset_in)
    apb_setup && !pwrite_in && paddr_in == EVA_VEC_ADDR && !line2_any
      |=> prdata_out == 32'h0000_0000)
    else $error("line 2 phantom offset not returned");

endmodule : pia_arbiter
`default_nettype wire

// ### test/pia_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pia_cpu_model
  import pia_pkg::*;
(
  input  wire logic        clk_in,        // system clock
  input  wire logic        reset_in,      // async reset, active high
  input  wire logic [3:0]  ack_delay_in,  // cycles waited before acknowledge
  input  wire logic        core_req_in,   // request from arbiter
  input  wire logic [3:0]  core_rank_in,  // rank presented
  input  wire logic        soft_interrupt_instruction_jam_in,   // jam pulse
  input  wire logic [15:0] jam_vector_in, // jammed vector
  output logic             cpu_ack_out,   // acknowledge pulse
  output logic      [3:0]  ack_rank_out,  // rank at last acknowledge
  output logic      [15:0] last_jam_out,  // vector of last jam
  output logic      [7:0]  n_jam_out      // jams seen
);
  logic [3:0] wait_r;

  // acknowledge after a programmable wait, one pulse per request
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cpu_ack_out  <= 1'b0;
      wait_r       <= 4'h0;
      ack_rank_out <= 4'h0;
    end
    else if (cpu_ack_out)
    begin
      cpu_ack_out <= 1'b0;
      wait_r      <= 4'h0;
    end
    else if (core_req_in && wait_r >= ack_delay_in)
    begin
      cpu_ack_out  <= 1'b1;
      ack_rank_out <= core_rank_in;
    end
    else if (core_req_in)
      wait_r <= wait_r + 4'h1;
    else
      wait_r <= 4'h0;
  end

  // core fetches the jammed soft interrupt vector
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      last_jam_out <= 16'h0000;
      n_jam_out    <= 8'h00;
    end
    else if (soft_interrupt_instruction_jam_in)
    begin
      last_jam_out <= jam_vector_in;
      n_jam_out    <= n_jam_out + 8'h01;
    end
  end
endmodule : pia_cpu_model
`default_nettype wire

// ### test/prioritized_interrupt_arbiter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_arbiter_tb_top
  import pia_pkg::*;
;
  logic        clk_in, reset_in, psel_in, penable_in, pwrite_in;
  logic [17:0] paddr_in, va;
  logic [31:0] pwdata_in, prdata_out, rd_data;
  logic        pready_out, pslverr_out, rd_err, pdp_in, nmi_low, emu_in;
  logic [2:0]  ext_in;
  logic [3:0]  sys_in, line_in, rank, ack_rank, ack_delay;
  logic [9:0]  ev_in;
  logic        ack, swint, swtrap, core_req, jam, gdis, irq_out;
  logic [15:0] core_vec, jam_vec, last_jam;
  logic [7:0]  n_jam;
  int          n_mismatch, checks_done, cycles;

  pia_arbiter u_pia_arbiter (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .ext_pin_irq_in(ext_in), .power_drive_protect_irq_in(pdp_in),
    .nmi_pin_low_in(nmi_low), .sys_periph_irq_in(sys_in), .ev_group_a_irq_in(ev_in),
    .line_req_in(line_in), .emu_trap_in(emu_in), .cpu_ack_in(ack), .cpu_swint_in(swint),
    .cpu_swint_trap_in(swtrap), .core_req_out(core_req), .core_rank_out(rank),
    .core_vector_out(core_vec), .soft_interrupt_instruction_jam_out(jam), .jam_vector_out(jam_vec),
    .global_irq_disable_out(gdis), .irq_out(irq_out));

  pia_cpu_model u_pia_cpu_model (.clk_in(clk_in), .reset_in(reset_in),
    .ack_delay_in(ack_delay), .core_req_in(core_req), .core_rank_in(rank),
    .soft_interrupt_instruction_jam_in(jam), .jam_vector_in(jam_vec), .cpu_ack_out(ack),
    .ack_rank_out(ack_rank), .last_jam_out(last_jam), .n_jam_out(n_jam));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    rd_data = prdata_out;
    rd_err  = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task rd(input logic [17:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd_data);
  endtask : rd

  task wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task wait_jam(input logic [7:0] k, input logic [15:0] vec, input logic [3:0] rk);
    int n;
    n = 0;
    while (n_jam !== k && n < 300)
    begin
      n++;
      @(posedge clk_in);
    end
    chk("jam count", {24'h00_0000, k}, {24'h00_0000, n_jam});
    chk("jam vector", {16'h0000, vec}, {16'h0000, last_jam});
    chk("ack rank", {28'h000_0000, rk}, {28'h000_0000, ack_rank});
  endtask : wait_jam

  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  initial
  begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {pdp_in, emu_in, ext_in, sys_in, line_in, ev_in, swint, swtrap} = '0;
    {n_mismatch, checks_done, cycles} = '0;
    nmi_low   = 1'b1;
    ack_delay = 4'h0;
    reset_in  = 1'b1;
    tick(12);
    reset_in <= 1'b0;
    tick(1);
    chk("disable out", 32'h0000_0001, {31'h0, gdis});
    chk("reset vector", {16'h0000, VEC_RESET}, {16'h0000, jam_vec});
    rd(ST0_ADDR, 32'h0000_0200, "status zero");
    rd(MASK_ADDR, 32'h0000_0000, "line mask");
    rd(18'h0_0040, 32'h0000_0000, "unmapped data");
    chk("unmapped err", 32'h0000_0001, {31'h0, rd_err});
    sys_in <= 4'hF;
    tick(1);
    sys_in <= 4'h0;
    tick(2);
    rd(SRC_BASE_ADDR + 18'h0_000C, 32'h0000_0001, "flag without enable");
    rd(SYS_VEC_ADDR, 32'h0000_0000, "gated vector");
    for (int i = 0; i < NUM_SRC; i++) wr(SRC_BASE_ADDR + 18'(4 * i), 32'h0000_0002);
    ext_in <= 3'h7;
    pdp_in <= 1'b1;
    ev_in  <= 10'h3FF;
    tick(1);
    ev_in <= 10'h000;
    tick(8);
    // each read must show the next source down the chain once the one above is cleared
    for (int i = 0; i < NUM_SRC; i++)
    begin
      va = (i < NUM_L1) ? SYS_VEC_ADDR : EVA_VEC_ADDR;
      rd(va, {16'h0000, SRC_OFS[i]}, "offset");
      wr(SRC_BASE_ADDR + 18'(4 * i), 32'h0000_0003);
    end
    rd(SYS_VEC_ADDR, 32'h0000_0000, "empty line 1 vector");
    rd(EVA_VEC_ADDR, 32'h0000_0000, "empty line 2 vector");
    rd(PEND_ADDR, 32'h0000_0003, "line pending");
    chk("req while disabled", 32'h0000_0000, {31'h0, core_req});
    wr(IEN_ADDR, 32'h0000_0040);
    wr(ST0_ADDR, 32'h0000_0000);
    tick(3);
    chk("req while masked", 32'h0000_0000, {31'h0, core_req});
    wr(MASK_ADDR, 32'h0000_0003);
    wait_jam(8'h01, LINE_VEC[0], RANK_LINE1);
    chk("disable after ack", 32'h0000_0001, {31'h0, gdis});
    tick(2);
    chk("phantom irq", 32'h0000_0001, {31'h0, irq_out});
    rd(ISTAT_ADDR, 32'h0000_0043, "irq status");
    wr(IEN_ADDR, 32'h0000_0000);
    tick(3);
    chk("irq disabled", 32'h0000_0000, {31'h0, irq_out});
    wr(ICLR_ADDR, 32'h0000_007F);
    rd(ISTAT_ADDR, 32'h0000_0000, "irq status cleared");
    ack_delay <= 4'h3;
    wr(ST0_ADDR, 32'h0000_0000);
    wait_jam(8'h02, LINE_VEC[1], RANK_LINE1 + 4'h1);
    nmi_low <= 1'b0;
    wait_jam(8'h03, VEC_NMI, RANK_NMI);
    nmi_low <= 1'b1;
    emu_in  <= 1'b1;
    tick(1);
    emu_in <= 1'b0;
    wait_jam(8'h04, VEC_EMU, RANK_EMU);
    line_in <= 4'hF;
    tick(1);
    line_in <= 4'h0;
    tick(2);
    rd(PEND_ADDR, 32'h0000_003C, "other lines pending");
    wr(MASK_ADDR, 32'h0000_0000);
    wr(ST0_ADDR, 32'h0000_0000);
    swint  <= 1'b1;
    swtrap <= 1'b1;
    tick(1);
    swint  <= 1'b0;
    swtrap <= 1'b0;
    tick(2);
    chk("trap keeps enable", 32'h0000_0000, {31'h0, gdis});
    swint <= 1'b1;
    tick(1);
    swint <= 1'b0;
    tick(2);
    chk("soft int disables", 32'h0000_0001, {31'h0, gdis});
    summarize();
  end
endmodule : prioritized_interrupt_arbiter_tb_top
`default_nettype wire
